// ---- design/pmr_entry_timer.sv ----
// one low-power entry timer: counts while entry conditions hold
// assumes conds and limit come from logic on the same clock
`timescale 1ns/1ps
module pmr_entry_timer #(
  parameter int TICK_NS = 1000
) (
  input wire logic clock,
  input wire logic rst,
  pmr_timer_if.tmr tif
);
  logic [pmr_pkg::ELAPSED_W-1:0] elapsed_q;
  logic [pmr_pkg::ELAPSED_W-1:0] elapsed_d;
  logic [pmr_pkg::ELAPSED_W-1:0] limit_ns;
  logic expired_q;

  // elapsed kept in ns so sub-cycle ticks round up to whole cycles
  assign limit_ns = pmr_pkg::ELAPSED_W'(tif.limit) * pmr_pkg::ELAPSED_W'(TICK_NS);

  always_comb begin
    if (!tif.conds) begin
      elapsed_d = '0;
    end else if (elapsed_q >= limit_ns) begin
      elapsed_d = elapsed_q; // saturates, no wrap
    end else begin
      elapsed_d = elapsed_q + pmr_pkg::ELAPSED_W'(pmr_pkg::CLK_PERIOD_NS);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      elapsed_q <= '0;
    end else begin
      elapsed_q <= elapsed_d;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      expired_q <= 1'b0;
    end else begin
      expired_q <= tif.conds && (elapsed_d >= limit_ns);
    end
  end

  assign tif.expired = expired_q;

  property p_restart;
    @(posedge clock) disable iff (rst) !tif.conds |=> (elapsed_q == '0) && !expired_q;
  endproperty
  a_restart: assert property (p_restart) else $error("timer did not restart");

  property p_no_early;
    @(posedge clock) disable iff (rst) (expired_q && $past(tif.conds)) |-> elapsed_q >= limit_ns;
  endproperty
  a_no_early: assert property (p_no_early) else $error("timer expired early");
endmodule // pmr_entry_timer

// ---- design/pmr_pkg.sv ----
// constants for the per-port power management register bank
// assumes a 100 MHz clock and byte addresses on the config access port
package pmr_pkg;
  // register byte offsets
  localparam logic [11:0] PM_CTRL_STS_OFS = 12'h074;
  localparam logic [11:0] LINK_PWR_TIMING_OFS = 12'h078;
  // pm_control_status field positions
  localparam int POWER_STATE_FIELD_LSB = 0;
  localparam int WAKE_EN_BIT = 8;
  localparam int WAKE_ST_BIT = 15;
  // link_power_timing_control field positions
  localparam int SLEEP_LSB = 0;
  localparam int SLEEP_W = 16;
  localparam int STANDBY_LSB = 16;
  localparam int STANDBY_W = 12;
  localparam int VIEW_BIT = 31;
  localparam int CODE_W = 6;
  // reset values
  localparam logic [1:0] POWER_STATE_FIELD_RST = 2'h0;
  localparam logic [SLEEP_W-1:0] SLEEP_RST = 16'h03E8;
  localparam logic [STANDBY_W-1:0] STANDBY_RST = 12'h6D6;
  localparam logic [CODE_W-1:0] CODE_RST = 6'h3F;
  // power state codes
  localparam logic [1:0] POWER_STATE_FIELD_D0 = 2'h0;
  localparam logic [1:0] POWER_STATE_FIELD_D3HOT = 2'h3;
  // state machine codes with fixed meaning
  localparam logic [CODE_W-1:0] CODE_L0 = 6'h00;
  localparam logic [CODE_W-1:0] CODE_L0S_ENTRY = 6'h01;
  localparam logic [CODE_W-1:0] CODE_L0S = 6'h02;
  localparam logic [CODE_W-1:0] CODE_LINK_DOWN = 6'h3F;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_TICK_NS = 1000;
  localparam int STANDBY_TICK_NS = 4;
  localparam int ELAPSED_W = 32;
endpackage

// ---- design/pmr_regs.sv ----
// per-port power management control/status and link power timing registers
// assumes config and management accesses arrive on one clocked request port,
// and that the link power state machine and entry conditions live outside
`timescale 1ns/1ps
module pmr_regs #(
  parameter int PORT_ID = 1,
  parameter int SLEEP_TICK_NS = pmr_pkg::SLEEP_TICK_NS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hot_rst,
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack_q,
  output logic [31:0] cfg_rdata_q,
  input wire logic port_is_upstream,
  input wire logic own_wake_event,
  input wire logic fwd_wake_event,
  input wire logic sleep_conds_met,
  input wire logic standby_conds_met,
  input wire logic link_up,
  input wire logic [5:0] fsm_code_in,
  output logic [1:0] power_state_q,
  output logic wake_msg_send_q,
  output logic sleep_entry_q,
  output logic standby_entry_q
);
  logic soft_rst;
  logic hit_power_fsm_state_code;
  logic hit_timing;
  logic wr_power_fsm_state_code;
  logic wr_timing;
  logic [1:0] power_state_field_q;
  logic wake_msg_enable;
  logic wake_msg_status;
  logic wake_send;
  logic [pmr_pkg::SLEEP_W-1:0] sleep_entry_timer_q;
  logic [pmr_pkg::STANDBY_W-1:0] standby_entry_timer_q;
  logic register_view_select_q;
  logic [pmr_pkg::CODE_W-1:0] power_fsm_state_code_q;
  logic [31:0] power_fsm_state_code_view;
  logic [31:0] timing_view;
  logic [31:0] rdata_d;

  pmr_timer_if sleep_if ();
  pmr_timer_if standby_if ();

  // hot reset clears only the non-sticky state
  assign soft_rst = rst || hot_rst;
  assign hit_power_fsm_state_code = cfg_addr[11:2] == pmr_pkg::PM_CTRL_STS_OFS[11:2];
  assign hit_timing = cfg_addr[11:2] == pmr_pkg::LINK_PWR_TIMING_OFS[11:2];
  assign wr_power_fsm_state_code = cfg_req && cfg_we && hit_power_fsm_state_code;
  assign wr_timing = cfg_req && cfg_we && hit_timing;

  // power state: reserved codes D1/D2 are dropped, old value kept
  always_ff @(posedge clock) begin
    if (soft_rst) begin
      power_state_field_q <= pmr_pkg::POWER_STATE_FIELD_RST;
    end else if (wr_power_fsm_state_code && cfg_byte_en[0]) begin
      if (cfg_wdata[pmr_pkg::POWER_STATE_FIELD_LSB +: 2] == pmr_pkg::POWER_STATE_FIELD_D0 ||
          cfg_wdata[pmr_pkg::POWER_STATE_FIELD_LSB +: 2] == pmr_pkg::POWER_STATE_FIELD_D3HOT) begin
        power_state_field_q <= cfg_wdata[pmr_pkg::POWER_STATE_FIELD_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (soft_rst) begin
      power_state_q <= pmr_pkg::POWER_STATE_FIELD_RST;
    end else if (wr_power_fsm_state_code && cfg_byte_en[0] &&
                 (cfg_wdata[pmr_pkg::POWER_STATE_FIELD_LSB +: 2] == pmr_pkg::POWER_STATE_FIELD_D0 ||
                  cfg_wdata[pmr_pkg::POWER_STATE_FIELD_LSB +: 2] == pmr_pkg::POWER_STATE_FIELD_D3HOT)) begin
      power_state_q <= cfg_wdata[pmr_pkg::POWER_STATE_FIELD_LSB +: 2];
    end
  end

  // forwarded wake messages are not wired into status at all
  pmr_wake_ctl #(
    .STATUS_PRESENT(PORT_ID != 0)
  ) u_wake (
    .clock(clock),
    .rst(rst),
    .en_wr(wr_power_fsm_state_code && cfg_byte_en[1]),
    .en_wdata(cfg_wdata[pmr_pkg::WAKE_EN_BIT]),
    .st_clr(wr_power_fsm_state_code && cfg_byte_en[1] && cfg_wdata[pmr_pkg::WAKE_ST_BIT]),
    .own_event(own_wake_event),
    .en_q(wake_msg_enable),
    .st_q(wake_msg_status),
    .send_q(wake_send)
  );
  assign wake_msg_send_q = wake_send;

  // timer fields are only writable while the timer view is shown
  always_ff @(posedge clock) begin
    if (soft_rst) begin
      sleep_entry_timer_q <= pmr_pkg::SLEEP_RST;
      standby_entry_timer_q <= pmr_pkg::STANDBY_RST;
    end else if (wr_timing && !register_view_select_q) begin
      if (cfg_byte_en[0]) begin
        sleep_entry_timer_q[7:0] <= cfg_wdata[7:0];
      end
      if (cfg_byte_en[1]) begin
        sleep_entry_timer_q[15:8] <= cfg_wdata[15:8];
      end
      if (cfg_byte_en[2]) begin
        standby_entry_timer_q[7:0] <= cfg_wdata[23:16];
      end
      if (cfg_byte_en[3]) begin
        standby_entry_timer_q[11:8] <= cfg_wdata[27:24];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (soft_rst) begin
      register_view_select_q <= 1'b0;
    end else if (wr_timing && cfg_byte_en[3]) begin
      register_view_select_q <= cfg_wdata[pmr_pkg::VIEW_BIT];
    end
  end

  // link down forces the fixed code whatever the machine reports
  always_ff @(posedge clock) begin
    if (soft_rst) begin
      power_fsm_state_code_q <= pmr_pkg::CODE_RST;
    end else if (!link_up) begin
      power_fsm_state_code_q <= pmr_pkg::CODE_LINK_DOWN;
    end else begin
      power_fsm_state_code_q <= fsm_code_in;
    end
  end

  // downstream ports never arm the sleep timer
  assign sleep_if.conds = sleep_conds_met && port_is_upstream;
  assign sleep_if.limit = sleep_entry_timer_q;
  assign standby_if.conds = standby_conds_met;
  assign standby_if.limit = {4'h0, standby_entry_timer_q};

  pmr_entry_timer #(
    .TICK_NS(SLEEP_TICK_NS)
  ) u_sleep_timer (
    .clock(clock),
    .rst(soft_rst),
    .tif(sleep_if)
  );

  pmr_entry_timer #(
    .TICK_NS(pmr_pkg::STANDBY_TICK_NS)
  ) u_standby_timer (
    .clock(clock),
    .rst(soft_rst),
    .tif(standby_if)
  );

  always_ff @(posedge clock) begin
    if (soft_rst) begin
      sleep_entry_q <= 1'b0;
      standby_entry_q <= 1'b0;
    end else begin
      sleep_entry_q <= sleep_if.expired && port_is_upstream;
      standby_entry_q <= standby_if.expired;
    end
  end

  // read views; data select, scale and data fields stay zero
  always_comb begin
    power_fsm_state_code_view = '0;
    power_fsm_state_code_view[pmr_pkg::POWER_STATE_FIELD_LSB +: 2] = power_state_field_q;
    power_fsm_state_code_view[pmr_pkg::WAKE_EN_BIT] = wake_msg_enable;
    power_fsm_state_code_view[pmr_pkg::WAKE_ST_BIT] = wake_msg_status;
  end

  always_comb begin
    timing_view = '0;
    if (register_view_select_q) begin
      timing_view[pmr_pkg::CODE_W-1:0] = power_fsm_state_code_q;
    end else begin
      timing_view[pmr_pkg::SLEEP_LSB +: pmr_pkg::SLEEP_W] = sleep_entry_timer_q;
      timing_view[pmr_pkg::STANDBY_LSB +: pmr_pkg::STANDBY_W] = standby_entry_timer_q;
    end
    timing_view[pmr_pkg::VIEW_BIT] = register_view_select_q;
  end

  // unmapped offsets read zero and are acknowledged like any other
  always_comb begin
    rdata_d = '0;
    if (hit_power_fsm_state_code) begin
      rdata_d = power_fsm_state_code_view;
    end else if (hit_timing) begin
      rdata_d = timing_view;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_ack_q <= 1'b0;
      cfg_rdata_q <= '0;
    end else begin
      cfg_ack_q <= cfg_req;
      cfg_rdata_q <= (cfg_req && !cfg_we) ? rdata_d : '0;
    end
  end

  property p_power_state_field_legal;
    @(posedge clock) disable iff (rst) power_state_q == pmr_pkg::POWER_STATE_FIELD_D0 || power_state_q == pmr_pkg::POWER_STATE_FIELD_D3HOT;
  endproperty
  a_power_state_field_legal: assert property (p_power_state_field_legal) else $error("reserved power state held");

  property p_power_state_field_write;
    @(posedge clock) disable iff (soft_rst)
      (wr_power_fsm_state_code && cfg_byte_en[0] && cfg_wdata[1:0] == pmr_pkg::POWER_STATE_FIELD_D3HOT) |=> power_state_q == pmr_pkg::POWER_STATE_FIELD_D3HOT;
  endproperty
  a_power_state_field_write: assert property (p_power_state_field_write) else $error("power state write lost");

  property p_hot_keeps_enable;
    @(posedge clock) disable iff (rst) (hot_rst && !(wr_power_fsm_state_code && cfg_byte_en[1])) |=> $stable(wake_msg_enable);
  endproperty
  a_hot_keeps_enable: assert property (p_hot_keeps_enable) else $error("hot reset changed wake enable");

  property p_fwd_no_status;
    @(posedge clock) disable iff (rst) (fwd_wake_event && !own_wake_event && !wake_msg_status) |=> !wake_msg_status;
  endproperty
  a_fwd_no_status: assert property (p_fwd_no_status) else $error("forwarded message set status");

  property p_port_a_zero;
    @(posedge clock) disable iff (rst) (PORT_ID == 0) |-> !wake_msg_status;
  endproperty
  a_port_a_zero: assert property (p_port_a_zero) else $error("port A status not zero");

  property p_zero_fields;
    @(posedge clock) disable iff (rst)
      (cfg_req && !cfg_we && hit_power_fsm_state_code) |=> cfg_ack_q && cfg_rdata_q[31:16] == 16'h0000 && cfg_rdata_q[14:9] == 6'h00;
  endproperty
  a_zero_fields: assert property (p_zero_fields) else $error("unimplemented field not zero");

  property p_code_view;
    @(posedge clock) disable iff (rst)
      (cfg_req && !cfg_we && hit_timing && register_view_select_q) |=> cfg_rdata_q[30:6] == 25'h0000000 && cfg_rdata_q[31];
  endproperty
  a_code_view: assert property (p_code_view) else $error("code view shows timer bits");

  property p_code_reset;
    @(posedge clock) $past(soft_rst) |-> power_fsm_state_code_q == pmr_pkg::CODE_RST;
  endproperty
  a_code_reset: assert property (p_code_reset) else $error("state code not 0x3F after reset");

  property p_down_code;
    @(posedge clock) disable iff (soft_rst) !link_up |=> power_fsm_state_code_q == pmr_pkg::CODE_LINK_DOWN;
  endproperty
  a_down_code: assert property (p_down_code) else $error("link down code wrong");

  property p_downstream_no_sleep;
    @(posedge clock) disable iff (soft_rst) !port_is_upstream |=> !sleep_entry_q;
  endproperty
  a_downstream_no_sleep: assert property (p_downstream_no_sleep) else $error("downstream used sleep timer");

  property p_reserved_ignored;
    @(posedge clock) disable iff (soft_rst)
      (wr_power_fsm_state_code && cfg_byte_en[0] && cfg_wdata[1:0] != pmr_pkg::POWER_STATE_FIELD_D0 &&
       cfg_wdata[1:0] != pmr_pkg::POWER_STATE_FIELD_D3HOT) |=> $stable(power_state_field_q);
  endproperty
  a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved power state taken");

  property p_view_locks_timers;
    @(posedge clock) disable iff (soft_rst)
      (wr_timing && register_view_select_q) |=> $stable(sleep_entry_timer_q) && $stable(standby_entry_timer_q);
  endproperty
  a_view_locks_timers: assert property (p_view_locks_timers) else $error("timer field written in code view");

  property p_hot_keeps_status;
    @(posedge clock) disable iff (rst)
      (hot_rst && !own_wake_event && !(wr_power_fsm_state_code && cfg_byte_en[1])) |=> $stable(wake_msg_status);
  endproperty
  a_hot_keeps_status: assert property (p_hot_keeps_status) else $error("hot reset changed wake status");

  property p_sleep_needs_conds;
    @(posedge clock) disable iff (soft_rst) sleep_entry_q |-> $past(sleep_conds_met, 2);
  endproperty
  a_sleep_needs_conds: assert property (p_sleep_needs_conds) else $error("sleep entry without conditions");

  property p_standby_needs_conds;
    @(posedge clock) disable iff (soft_rst) standby_entry_q |-> $past(standby_conds_met, 2);
  endproperty
  a_standby_needs_conds: assert property (p_standby_needs_conds) else $error("standby entry without conditions");
endmodule // pmr_regs

// ---- design/pmr_timer_if.sv ----
// entry timer hand-off between the register bank and one timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface pmr_timer_if;
  logic conds;
  logic [15:0] limit;
  logic expired;
  modport ctl (output conds, output limit, input expired);
  modport tmr (input conds, input limit, output expired);
endinterface

// ---- design/pmr_wake_ctl.sv ----
// wake message enable and status, both sticky across hot reset
// assumes event pulses from logic on the same clock
`timescale 1ns/1ps
module pmr_wake_ctl #(
  parameter bit STATUS_PRESENT = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic en_wr,
  input wire logic en_wdata,
  input wire logic st_clr,
  input wire logic own_event,
  output logic en_q,
  output logic st_q,
  output logic send_q
);
  // hot reset is absent on purpose: both bits are sticky
  always_ff @(posedge clock) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (en_wr) begin
      en_q <= en_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || !STATUS_PRESENT) begin
      st_q <= 1'b0;
    end else if (own_event) begin
      st_q <= 1'b1; // set beats clear
    end else if (st_clr) begin
      st_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      send_q <= 1'b0;
    end else begin
      send_q <= own_event && en_q;
    end
  end

  property p_send_gated;
    @(posedge clock) disable iff (rst) send_q |-> $past(en_q) && $past(own_event);
  endproperty
  a_send_gated: assert property (p_send_gated) else $error("wake message without enable");

  property p_status_set;
    @(posedge clock) disable iff (rst) (own_event && STATUS_PRESENT) |=> st_q;
  endproperty
  a_status_set: assert property (p_status_set) else $error("own event did not set status");
endmodule // pmr_wake_ctl

// ---- testbench/pmr_link_partner.sv ----
// link side model: power fsm code source and wake event source
// assumes its tasks are called from the bench on the 100 MHz clock
`timescale 1ns/1ps
module pmr_link_partner (
  input wire logic clock,
  output logic link_up,
  output logic [5:0] fsm_code_in,
  output logic own_wake_event,
  output logic fwd_wake_event
);
  initial begin
    link_up = 1'b0;
    fsm_code_in = 6'h3F;
    own_wake_event = 1'b0;
    fwd_wake_event = 1'b0;
  end
  // code changes only after an edge, held until the next call
  task automatic set_code(input logic up, input logic [5:0] code);
    @(posedge clock) #1;
    link_up = up;
    fsm_code_in = code;
  endtask
  // one-cycle wake pulse; fwd stands for a passed-through message
  task automatic pulse(input logic fwd);
    @(posedge clock) #1;
    if (fwd) begin
      fwd_wake_event = 1'b1;
    end else begin
      own_wake_event = 1'b1;
    end
    @(posedge clock) #1;
    own_wake_event = 1'b0;
    fwd_wake_event = 1'b0;
  endtask
endmodule // pmr_link_partner

// ---- testbench/pmr_regs_bench.sv ----
// self-checking bench for the power management register bank
// assumes pmr_regs, pmr_pkg and the link partner model are compiled first
`timescale 1ns/1ps
module pmr_regs_bench;
  logic clock;
  logic rst;
  logic hot_rst;
  logic cfg_req;
  logic cfg_we;
  logic [11:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata;
  logic cfg_ack_q;
  logic [31:0] cfg_rdata_q;
  logic port_is_upstream;
  logic link_up;
  logic [5:0] fsm_code_in;
  logic own_wake_event;
  logic fwd_wake_event;
  logic sleep_conds_met;
  logic standby_conds_met;
  logic [1:0] power_state_q;
  logic wake_msg_send_q;
  logic sleep_entry_q;
  logic standby_entry_q;
  logic [31:0] rd;
  logic [31:0] cfg_rdata_a;
  logic [31:0] rd_a;
  int failures;
  int tests_run;
  int n;
  // tick of 10 ns makes one sleep tick one cycle
  localparam int TICK = 10;

  pmr_regs #(.PORT_ID(1), .SLEEP_TICK_NS(TICK)) pmr_regs_inst (
    .clock(clock), .rst(rst), .hot_rst(hot_rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack_q(cfg_ack_q),
    .cfg_rdata_q(cfg_rdata_q), .port_is_upstream(port_is_upstream), .own_wake_event(own_wake_event),
    .fwd_wake_event(fwd_wake_event), .sleep_conds_met(sleep_conds_met),
    .standby_conds_met(standby_conds_met), .link_up(link_up), .fsm_code_in(fsm_code_in),
    .power_state_q(power_state_q), .wake_msg_send_q(wake_msg_send_q),
    .sleep_entry_q(sleep_entry_q), .standby_entry_q(standby_entry_q));

  // port A twin on the same bus; only its read data is watched
  pmr_regs #(.PORT_ID(0), .SLEEP_TICK_NS(TICK)) pmr_regs_a_inst (
    .clock(clock), .rst(rst), .hot_rst(hot_rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_ack_q(),
    .cfg_rdata_q(cfg_rdata_a), .port_is_upstream(port_is_upstream), .own_wake_event(own_wake_event),
    .fwd_wake_event(fwd_wake_event), .sleep_conds_met(sleep_conds_met),
    .standby_conds_met(standby_conds_met), .link_up(link_up), .fsm_code_in(fsm_code_in),
    .power_state_q(), .wake_msg_send_q(), .sleep_entry_q(), .standby_entry_q());

  pmr_link_partner pmr_link_partner_inst (
    .clock(clock), .link_up(link_up), .fsm_code_in(fsm_code_in),
    .own_wake_event(own_wake_event), .fwd_wake_event(fwd_wake_event));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // one access; ack and data stand only in the cycle after the request
  task automatic acc(input logic we, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clock) #1;
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_byte_en = be;
    cfg_wdata = d;
    @(posedge clock) #1;
    cfg_req = 1'b0;
    rd = cfg_rdata_q;
    rd_a = cfg_rdata_a;
    chk_word("cfg_ack_q", 32'h1, {31'h0, cfg_ack_q});
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    acc(1'b0, a, 4'h0, 32'h0);
    chk_word(what, exp, rd);
  endtask

  task automatic set_conds(input bit sl, input logic v);
    if (sl) begin
      sleep_conds_met = v;
    end else begin
      standby_conds_met = v;
    end
  endtask

  // edges from raising conds until the entry output is high, then drop
  task automatic measure(input bit sl, output int cnt);
    set_conds(sl, 1'b1);
    cnt = 0;
    do begin
      @(posedge clock) #1;
      cnt++;
    end while ((sl ? sleep_entry_q : standby_entry_q) !== 1'b1 && cnt < 60);
    set_conds(sl, 1'b0);
    // the entry output sits two flops behind conds, so it falls on the second edge
    repeat (2) @(posedge clock);
    #1 chk_word("entry drop", 32'h0, {31'h0, sl ? sleep_entry_q : standby_entry_q});
  endtask

  initial begin
    #20000;
    failures++;
    $display("ERROR watchdog expected finish seen hang");
    final_report();
  end

  initial begin
    rst = 1'b1;
    hot_rst = 1'b0;
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 12'h000;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h00000000;
    port_is_upstream = 1'b1;
    sleep_conds_met = 1'b0;
    standby_conds_met = 1'b0;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    rdchk("pm_control_status", pmr_pkg::PM_CTRL_STS_OFS, 32'h00000000);
    rdchk("link_power_timing_control", pmr_pkg::LINK_PWR_TIMING_OFS, 32'h06D603E8);
    rdchk("unmapped", 12'h07C, 32'h00000000);
    $display("test reset values done");
    acc(1'b1, 12'h074, 4'hF, 32'h00000003);
    chk_word("power_state_q", 32'h3, {30'h0, power_state_q});
    acc(1'b1, 12'h074, 4'h1, 32'h00000001);
    rdchk("reserved state 1", 12'h074, 32'h00000003);
    acc(1'b1, 12'h074, 4'h1, 32'h00000002);
    rdchk("reserved state 2", 12'h074, 32'h00000003);
    acc(1'b1, 12'h074, 4'h1, 32'h00000000);
    rdchk("state d0", 12'h074, 32'h00000000);
    // all ones, as an init agent presetting the enable would
    acc(1'b1, 12'h074, 4'hF, 32'hFFFFFFFF);
    rdchk("read-zero fields", 12'h074, 32'h00000103);
    $display("test power state done");
    pmr_link_partner_inst.pulse(1'b0);
    chk_word("wake_msg_send_q on", 32'h1, {31'h0, wake_msg_send_q});
    rdchk("status set", 12'h074, 32'h00008103);
    chk_word("port a status", 32'h00000103, rd_a);
    acc(1'b1, 12'h074, 4'h2, 32'h00008000);
    rdchk("status cleared", 12'h074, 32'h00000003);
    pmr_link_partner_inst.pulse(1'b0);
    chk_word("wake_msg_send_q off", 32'h0, {31'h0, wake_msg_send_q});
    rdchk("status without enable", 12'h074, 32'h00008003);
    acc(1'b1, 12'h074, 4'h2, 32'h00008100);
    pmr_link_partner_inst.pulse(1'b1);
    chk_word("send on forward", 32'h0, {31'h0, wake_msg_send_q});
    rdchk("forward leaves status", 12'h074, 32'h00000103);
    $display("test wake done");
    acc(1'b1, 12'h078, 4'hF, 32'h00050006);
    rdchk("timer fields", 12'h078, 32'h00050006);
    measure(1'b0, n);
    chk_cnt("standby edges", (5 * pmr_pkg::STANDBY_TICK_NS + 9) / 10 + 1, n);
    measure(1'b1, n);
    chk_cnt("sleep edges", (6 * TICK + 9) / 10 + 1, n);
    set_conds(1'b1, 1'b1);
    repeat (4) @(posedge clock);
    #1 set_conds(1'b1, 1'b0);
    @(posedge clock) #1;
    measure(1'b1, n);
    chk_cnt("sleep edges after drop", (6 * TICK + 9) / 10 + 1, n);
    port_is_upstream = 1'b0;
    set_conds(1'b1, 1'b1);
    repeat (15) @(posedge clock);
    #1 chk_word("sleep on downstream", 32'h0, {31'h0, sleep_entry_q});
    set_conds(1'b1, 1'b0);
    port_is_upstream = 1'b1;
    $display("test timers done");
    // code read here stands for the management port read
    pmr_link_partner_inst.set_code(1'b1, pmr_pkg::CODE_L0S);
    acc(1'b1, 12'h078, 4'hF, 32'h80050006);
    rdchk("code l0s", 12'h078, 32'h80000002);
    pmr_link_partner_inst.set_code(1'b1, pmr_pkg::CODE_L0S_ENTRY);
    rdchk("code entry", 12'h078, 32'h80000001);
    pmr_link_partner_inst.set_code(1'b1, pmr_pkg::CODE_L0);
    rdchk("code l0", 12'h078, 32'h80000000);
    pmr_link_partner_inst.set_code(1'b0, 6'h05);
    rdchk("code down", 12'h078, 32'h8000003F);
    acc(1'b1, 12'h078, 4'hF, 32'h80FF0FFF);
    acc(1'b1, 12'h078, 4'hF, 32'h00000000);
    rdchk("timers kept in code view", 12'h078, 32'h00050006);
    $display("test view done");
    pmr_link_partner_inst.pulse(1'b0);
    acc(1'b1, 12'h074, 4'h1, 32'h00000003);
    @(posedge clock) #1 hot_rst = 1'b1;
    @(posedge clock) #1 hot_rst = 1'b0;
    chk_word("power_state_q hot", 32'h0, {30'h0, power_state_q});
    rdchk("sticky after hot", 12'h074, 32'h00008100);
    rdchk("timers after hot", 12'h078, 32'h06D603E8);
    acc(1'b1, 12'h078, 4'h8, 32'h80000000);
    rdchk("code after hot", 12'h078, 32'h8000003F);
    @(posedge clock) #1 rst = 1'b1;
    @(posedge clock) #1 rst = 1'b0;
    rdchk("fundamental reset", 12'h074, 32'h00000000);
    $display("test resets done");
    final_report();
  end
endmodule // pmr_regs_bench
